//--- hw/bcs_map.svh
/*
 Register offsets, field positions, reset values and sizes of the burst and calendar status block.
 Assumes inclusion by bare name from the block's SystemVerilog sources; holds definitions only.
*/
// Operation
// - Transmit flags short burst below minimum, unless closing control word has end-of-packet.
// - Realign request high resets lane logic, then lanes resync and realign.
// - Receive flags burst longer than configured maximum; flag is informational.
// - Lane-health output holds latest diagnostic word bit 33 per lane.
// - Interface-health output holds latest diagnostic word bit 32 per lane.
// - Check-ok follows CRC32 result of the most recent diagnostic word.
// - Check-fail pulses one cycle per lane on each bad diagnostic CRC32.
// - Calendar outputs come from control word bits 55-40; one is XON.
// - At most 256 calendar entries; later entries are dropped.
// - Calendar bits not updated by a short calendar keep their values.
// - First received calendar entry lands on bit 0, then onward.
// - CRC24 error or alignment loss clears all calendar bits to XOFF.
// - Multi-use output holds bits 31:24 of latest control word.
// - Multi-use output domain depends on retransmission; one clock serves both here.
// - Alignment-lost flag rises on alignment error or loss of alignment.
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH

`define BCS_LANES 12
`define BCS_WORD_W 64
`define BCS_BURST_W 8
`define BCS_MU_W 8
`define BCS_CAL_ENTRIES 256
`define BCS_CAL_BLK_W 16
`define BCS_CAL_BLOCKS 5'h10
`define BCS_CAL_PTR_W 5

// Control word fields
`define BCS_CW_CAL_START 56
`define BCS_CW_CAL_HI 55
`define BCS_CW_MU_HI 31
`define BCS_CW_MU_LO 24

// Register map (byte addresses)
`define BCS_ADDR_W 8
`define BCS_ADDR_BURST 8'h00
`define BCS_ADDR_IRQ_STAT 8'h04
`define BCS_ADDR_IRQ_MASK 8'h08
`define BCS_ADDR_LANE_HEALTH 8'h0C
`define BCS_ADDR_INTF_HEALTH 8'h10
`define BCS_ADDR_CHECK_OK 8'h14
`define BCS_ADDR_MISC 8'h18
`define BCS_ADDR_CAL_PAGE 3'h1
`define BCS_CAL_PAGE_HI 7
`define BCS_CAL_PAGE_LO 5
`define BCS_CAL_SEL_HI 4
`define BCS_CAL_SEL_LO 2
`define BCS_RD_W 32
`define BCS_CAL_WORDS 8

// Burst register fields
`define BCS_BURST_MIN_LO 0
`define BCS_BURST_MAX_LO 8
`define BCS_BURST_MIN_RST 8'h02
`define BCS_BURST_MAX_RST 8'h08

// Interrupt bits
`define BCS_IRQ_W 5
`define BCS_IRQ_TX_SHORT 0
`define BCS_IRQ_RX_LONG 1
`define BCS_IRQ_DIAG_FAIL 2
`define BCS_IRQ_ALIGN_LOST 3
`define BCS_IRQ_CRC24 4
`define BCS_IRQ_MASK_RST 5'h00

// Misc register fields
`define BCS_MISC_ALIGN_ERR 8
`define BCS_MISC_LANE_RESET 9

`endif

//--- hw/bcs_pkg.sv
/*
 Types shared by the burst and calendar status block.
 Assumes the map header supplies the sizes.
*/
`include "bcs_map.svh"

package bcs_pkg;
	typedef logic [`BCS_BURST_W-1:0] bcs_burst_len_t;
	typedef enum logic {BCS_CHK_SHORT, BCS_CHK_LONG} bcs_chk_mode_t;
endpackage

//--- hw/bcs_word_if.sv
/*
 Word stream carrier between the core and its burst checkers.
 Assumes one word per valid cycle on a single clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface bcs_word_if;
	logic valid;
	logic is_ctrl;
	logic eop;
	modport src (output valid, output is_ctrl, output eop);
	modport sink (input valid, input is_ctrl, input eop);
endinterface

`default_nettype wire

//--- hw/bcs_burst_chk.sv
/*
 Burst length checker: counts data words between control words and pulses an error flag.
 Assumes words arrive on the core clock; the limit is stable while a burst runs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

module bcs_burst_chk #(
	parameter bcs_pkg::bcs_chk_mode_t MODE = bcs_pkg::BCS_CHK_SHORT
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	bcs_word_if.sink words,
	input wire bcs_pkg::bcs_burst_len_t i_limit,
	output logic o_err
);
	bcs_pkg::bcs_burst_len_t cnt_q;
	logic err_d;
	logic err_q;

	////////////////////////////////////////////////////////////////
	// Counter saturates so a runaway burst never wraps back under the limit
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else if (words.valid && words.is_ctrl) begin
			cnt_q <= '0;
		end else if (words.valid && (cnt_q != '1)) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		err_d = 1'b0;
		if (words.valid && words.is_ctrl) begin
			case (MODE)
				bcs_pkg::BCS_CHK_SHORT: err_d = (cnt_q != '0) && (cnt_q < i_limit) && !words.eop;
				bcs_pkg::BCS_CHK_LONG: err_d = cnt_q > i_limit;
				default: err_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_q <= 1'b0;
		end else begin
			err_q <= err_d;
		end
	end

	assign o_err = err_q;
endmodule // bcs_burst_chk

`default_nettype wire

//--- hw/bcs_lane_diag.sv
/*
 Per-lane diagnostic word status: health bits, checksum result and failure pulse.
 Assumes lane logic delivers each decoded diagnostic word as a one-cycle strobe on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

module bcs_lane_diag (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [`BCS_LANES-1:0] i_diag_valid,
	input wire logic [`BCS_LANES-1:0] i_diag_bit33,
	input wire logic [`BCS_LANES-1:0] i_diag_bit32,
	input wire logic [`BCS_LANES-1:0] i_diag_crc_ok,
	output logic [`BCS_LANES-1:0] o_lane_health,
	output logic [`BCS_LANES-1:0] o_intf_health,
	output logic [`BCS_LANES-1:0] o_check_ok,
	output logic [`BCS_LANES-1:0] o_check_fail
);
	logic [`BCS_LANES-1:0] lane_q;
	logic [`BCS_LANES-1:0] intf_q;
	logic [`BCS_LANES-1:0] ok_q;
	logic [`BCS_LANES-1:0] fail_q;

	genvar g;
	generate
		for (g = 0; g < `BCS_LANES; g++) begin : g_lane
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					lane_q[g] <= 1'b0;
					intf_q[g] <= 1'b0;
					ok_q[g] <= 1'b0;
				end else if (i_diag_valid[g]) begin
					lane_q[g] <= i_diag_bit33[g];
					intf_q[g] <= i_diag_bit32[g];
					ok_q[g] <= i_diag_crc_ok[g];
				end
			end

			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					fail_q[g] <= 1'b0;
				end else begin
					fail_q[g] <= i_diag_valid[g] && !i_diag_crc_ok[g];
				end
			end
		end
	endgenerate

	assign o_lane_health = lane_q;
	assign o_intf_health = intf_q;
	assign o_check_ok = ok_q;
	assign o_check_fail = fail_q;
endmodule // bcs_lane_diag

`default_nettype wire

//--- hw/bcs_core.sv
/*
 Burst and calendar status core: burst checks, realign request, diagnostic status,
 flow-control calendar, multi-use field, alignment-lost flag, register port and interrupt.
 Assumes word streams, lane status and error strobes come from logic on i_clk;
 only the realign request is asynchronous.
*/
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

module bcs_core (
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [`BCS_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_irq,
	// Transmit word stream
	input wire logic i_tx_valid,
	input wire logic i_tx_is_ctrl,
	input wire logic i_tx_eop,
	output logic o_tx_short_burst_err,
	// Receive word stream
	input wire logic i_rx_valid,
	input wire logic i_rx_is_ctrl,
	input wire logic [`BCS_WORD_W-1:0] i_rx_word,
	input wire logic i_rx_crc24_err,
	input wire logic i_rx_aligned,
	input wire logic i_rx_align_fail,
	input wire logic i_rx_realign_req,
	output logic o_rx_long_burst_err,
	output logic o_rx_lane_reset,
	output logic o_rx_aligned_err,
	// Diagnostic words from lane logic
	input wire logic [`BCS_LANES-1:0] i_diag_valid,
	input wire logic [`BCS_LANES-1:0] i_diag_bit33,
	input wire logic [`BCS_LANES-1:0] i_diag_bit32,
	input wire logic [`BCS_LANES-1:0] i_diag_crc_ok,
	output logic [`BCS_LANES-1:0] o_rx_lane_health_bits,
	output logic [`BCS_LANES-1:0] o_rx_interface_health_bits,
	output logic [`BCS_LANES-1:0] o_rx_diag_check_ok,
	output logic [`BCS_LANES-1:0] o_rx_diag_check_fail,
	output logic [`BCS_CAL_ENTRIES-1:0] o_rx_calendar_xon_bits,
	output logic [`BCS_MU_W-1:0] o_rx_multi_use_field
);
	bcs_word_if tx_if ();
	bcs_word_if rx_if ();

	bcs_pkg::bcs_burst_len_t burst_min_q;
	bcs_pkg::bcs_burst_len_t burst_max_q;
	logic [`BCS_IRQ_W-1:0] irq_stat_q;
	logic [`BCS_IRQ_W-1:0] irq_mask_q;
	logic [`BCS_IRQ_W-1:0] irq_event;
	logic irq_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic resync_meta_q;
	logic resync_q;
	logic lane_reset_q;
	logic aligned_prev_q;
	logic align_lost;
	logic align_err_q;
	logic ctrl_word;
	logic cal_clear;
	logic [`BCS_CAL_ENTRIES-1:0] cal_q;
	logic [`BCS_CAL_ENTRIES-1:0] cal_d;
	logic [`BCS_CAL_PTR_W-1:0] cal_ptr_q;
	logic [`BCS_CAL_PTR_W-1:0] cal_ptr_d;
	logic [`BCS_CAL_PTR_W-1:0] cal_blk;
	logic [`BCS_MU_W-1:0] mu_q;

	////////////////////////////////////////////////////////////////
	// Burst checkers
	assign tx_if.valid = i_tx_valid;
	assign tx_if.is_ctrl = i_tx_is_ctrl;
	assign tx_if.eop = i_tx_eop;
	assign rx_if.valid = i_rx_valid && !lane_reset_q;
	assign rx_if.is_ctrl = i_rx_is_ctrl;
	assign rx_if.eop = 1'b0;

	bcs_burst_chk #(.MODE(bcs_pkg::BCS_CHK_SHORT)) u_tx_chk (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.words(tx_if.sink),
		.i_limit(burst_min_q),
		.o_err(o_tx_short_burst_err)
	);

	bcs_burst_chk #(.MODE(bcs_pkg::BCS_CHK_LONG)) u_rx_chk (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.words(rx_if.sink),
		.i_limit(burst_max_q),
		.o_err(o_rx_long_burst_err)
	);

	////////////////////////////////////////////////////////////////
	// Diagnostic words
	bcs_lane_diag u_diag (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_diag_valid(i_diag_valid),
		.i_diag_bit33(i_diag_bit33),
		.i_diag_bit32(i_diag_bit32),
		.i_diag_crc_ok(i_diag_crc_ok),
		.o_lane_health(o_rx_lane_health_bits),
		.o_intf_health(o_rx_interface_health_bits),
		.o_check_ok(o_rx_diag_check_ok),
		.o_check_fail(o_rx_diag_check_fail)
	);

	////////////////////////////////////////////////////////////////
	// Realign request is asynchronous, so it is synchronised first
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			resync_meta_q <= 1'b0;
			resync_q <= 1'b0;
		end else begin
			resync_meta_q <= i_rx_realign_req;
			resync_q <= resync_meta_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lane_reset_q <= 1'b0;
		end else begin
			lane_reset_q <= resync_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// alignment lost detect
	assign align_lost = i_rx_align_fail || (aligned_prev_q && !i_rx_aligned);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aligned_prev_q <= 1'b0;
			align_err_q <= 1'b0;
		end else begin
			aligned_prev_q <= i_rx_aligned;
			align_err_q <= align_lost;
		end
	end

	////////////////////////////////////////////////////////////////
	// Flow-control calendar
	assign ctrl_word = i_rx_valid && i_rx_is_ctrl && !lane_reset_q;
	assign cal_clear = i_rx_crc24_err || align_lost || lane_reset_q;
	assign cal_blk = i_rx_word[`BCS_CW_CAL_START] ? '0 : cal_ptr_q;

	always_comb begin
		cal_d = cal_q;
		cal_ptr_d = cal_ptr_q;
		if (cal_clear) begin
			cal_d = '0;
			cal_ptr_d = `BCS_CAL_BLOCKS;
		end else if (ctrl_word && (cal_blk < `BCS_CAL_BLOCKS)) begin
			for (int k = 0; k < `BCS_CAL_BLK_W; k++) begin
				cal_d[{cal_blk[3:0], 4'(k)}] = i_rx_word[`BCS_CW_CAL_HI - k];
			end
			cal_ptr_d = cal_blk + 1'b1;
		end
		// beyond 256 entries nothing is written
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cal_q <= '0;
			cal_ptr_q <= `BCS_CAL_BLOCKS;
		end else begin
			cal_q <= cal_d;
			cal_ptr_q <= cal_ptr_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// multi-use field capture
	// core and user clocks are one clock in this build
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mu_q <= '0;
		end else if (ctrl_word) begin
			mu_q <= i_rx_word[`BCS_CW_MU_HI:`BCS_CW_MU_LO];
		end
	end

	////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			burst_min_q <= `BCS_BURST_MIN_RST;
			burst_max_q <= `BCS_BURST_MAX_RST;
		end else if (i_wr && (i_addr == `BCS_ADDR_BURST)) begin
			burst_min_q <= i_wdata[`BCS_BURST_MIN_LO +: `BCS_BURST_W];
			burst_max_q <= i_wdata[`BCS_BURST_MAX_LO +: `BCS_BURST_W];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_mask_q <= `BCS_IRQ_MASK_RST;
		end else if (i_wr && (i_addr == `BCS_ADDR_IRQ_MASK)) begin
			irq_mask_q <= i_wdata[`BCS_IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status: a new event wins over a write-one clear in the same cycle
	always_comb begin
		irq_event = '0;
		irq_event[`BCS_IRQ_TX_SHORT] = o_tx_short_burst_err;
		irq_event[`BCS_IRQ_RX_LONG] = o_rx_long_burst_err;
		irq_event[`BCS_IRQ_DIAG_FAIL] = |o_rx_diag_check_fail;
		irq_event[`BCS_IRQ_ALIGN_LOST] = align_err_q;
		irq_event[`BCS_IRQ_CRC24] = i_rx_crc24_err;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat_q <= '0;
		end else if (i_wr && (i_addr == `BCS_ADDR_IRQ_STAT)) begin
			irq_stat_q <= (irq_stat_q & ~i_wdata[`BCS_IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_q <= irq_stat_q | irq_event;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |((irq_stat_q | irq_event) & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port: data stands one cycle after the strobe, unmapped reads zero
	always_comb begin
		rdata_d = '0;
		if (i_addr[`BCS_CAL_PAGE_HI:`BCS_CAL_PAGE_LO] == `BCS_ADDR_CAL_PAGE) begin
			rdata_d = cal_q[i_addr[`BCS_CAL_SEL_HI:`BCS_CAL_SEL_LO] * `BCS_RD_W +: `BCS_RD_W];
		end else begin
			case (i_addr)
				`BCS_ADDR_BURST: begin
					rdata_d[`BCS_BURST_MIN_LO +: `BCS_BURST_W] = burst_min_q;
					rdata_d[`BCS_BURST_MAX_LO +: `BCS_BURST_W] = burst_max_q;
				end
				`BCS_ADDR_IRQ_STAT: rdata_d[`BCS_IRQ_W-1:0] = irq_stat_q;
				`BCS_ADDR_IRQ_MASK: rdata_d[`BCS_IRQ_W-1:0] = irq_mask_q;
				`BCS_ADDR_LANE_HEALTH: rdata_d[`BCS_LANES-1:0] = o_rx_lane_health_bits;
				`BCS_ADDR_INTF_HEALTH: rdata_d[`BCS_LANES-1:0] = o_rx_interface_health_bits;
				`BCS_ADDR_CHECK_OK: rdata_d[`BCS_LANES-1:0] = o_rx_diag_check_ok;
				`BCS_ADDR_MISC: begin
					rdata_d[`BCS_MU_W-1:0] = mu_q;
					rdata_d[`BCS_MISC_ALIGN_ERR] = align_err_q;
					rdata_d[`BCS_MISC_LANE_RESET] = lane_reset_q;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= '0;
		end else if (i_rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= '0;
		end
	end

	assign o_rdata = rdata_q;
	assign o_irq = irq_q;
	assign o_rx_lane_reset = lane_reset_q;
	assign o_rx_aligned_err = align_err_q;
	assign o_rx_calendar_xon_bits = cal_q;
	assign o_rx_multi_use_field = mu_q;
endmodule // bcs_core

`default_nettype wire

//--- bench/bcs_far_model.sv
/*
 Far side of the block: receive word source and realign request of the user logic.
 Assumes one clock, words presented right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module bcs_far_model (
	input wire logic i_clk,
	output logic o_valid,
	output logic o_is_ctrl,
	output logic [63:0] o_word,
	output logic o_realign
);
	initial begin
		o_valid = 1'b0;
		o_is_ctrl = 1'b0;
		o_word = 64'h0;
		o_realign = 1'b0;
	end

	// Idle word shows the inverse so a stale capture is caught
	task send(input logic c, input logic [63:0] w);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_is_ctrl <= c;
		o_word <= w;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_word <= ~w;
	endtask

	task realign(input int n);
		@(posedge i_clk);
		o_realign <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_realign <= 1'b0;
	endtask
endmodule // bcs_far_model

`default_nettype wire

//--- bench/bcs_core_chk.sv
/*
 Port checker for bcs_core.
 Assumes single clock, stimulus changed right after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

module bcs_core_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tx_valid,
	input wire logic i_tx_is_ctrl,
	input wire logic i_tx_eop,
	input wire logic o_tx_short_burst_err,
	input wire logic i_rx_valid,
	input wire logic i_rx_is_ctrl,
	input wire logic [`BCS_WORD_W-1:0] i_rx_word,
	input wire logic i_rx_crc24_err,
	input wire logic i_rx_aligned,
	input wire logic i_rx_align_fail,
	input wire logic i_rx_realign_req,
	input wire logic o_rx_long_burst_err,
	input wire logic o_rx_lane_reset,
	input wire logic o_rx_aligned_err,
	input wire logic [`BCS_LANES-1:0] i_diag_valid,
	input wire logic [`BCS_LANES-1:0] i_diag_crc_ok,
	input wire logic [`BCS_LANES-1:0] o_rx_diag_check_ok,
	input wire logic [`BCS_LANES-1:0] o_rx_diag_check_fail,
	input wire logic [`BCS_CAL_ENTRIES-1:0] o_rx_calendar_xon_bits,
	input wire logic [`BCS_MU_W-1:0] o_rx_multi_use_field
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire [`BCS_LANES-1:0] fail_in = i_diag_valid & ~i_diag_crc_ok;
	wire [`BCS_LANES-1:0] ok_in = i_diag_valid & i_diag_crc_ok;
	wire [7:0] mu_in = i_rx_word[`BCS_CW_MU_HI:`BCS_CW_MU_LO];
	wire tx_close = i_tx_valid & i_tx_is_ctrl & ~i_tx_eop;
	wire rx_ctrl = i_rx_valid & i_rx_is_ctrl;
	sequence s_req_on;
		i_rx_realign_req [*3];
	endsequence
	sequence s_req_off;
		!i_rx_realign_req [*3];
	endsequence
	////////////////////////////////////////
	AST_CHK_FAIL: assert property (1'b1 |=> o_rx_diag_check_fail == $past(fail_in))
		else $error("check fail pulse wrong");
	AST_CHK_OK: assert property (|i_diag_valid |=> (o_rx_diag_check_ok & $past(i_diag_valid)) == $past(ok_in))
		else $error("check ok wrong");
	AST_MU: assert property (rx_ctrl && !o_rx_lane_reset |=> o_rx_multi_use_field == $past(mu_in))
		else $error("multi use field wrong");
	AST_CAL_CLR: assert property (i_rx_crc24_err |=> o_rx_calendar_xon_bits == '0)
		else $error("calendar not cleared");
	AST_ALIGN: assert property (i_rx_align_fail || $fell(i_rx_aligned) |=> o_rx_aligned_err)
		else $error("alignment flag missing");
	AST_REALIGN_ON: assert property (s_req_on |=> o_rx_lane_reset)
		else $error("lane reset missing");
	AST_REALIGN_OFF: assert property (s_req_off |=> !o_rx_lane_reset)
		else $error("lane reset stuck");
	AST_TX_SHORT: assert property (o_tx_short_burst_err |-> $past(tx_close) ##1 !o_tx_short_burst_err)
		else $error("short burst flag wrong");
	AST_RX_LONG: assert property (o_rx_long_burst_err |-> $past(rx_ctrl) ##1 !o_rx_long_burst_err)
		else $error("long burst flag wrong");
endmodule // bcs_core_chk

bind bcs_core bcs_core_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_valid(i_tx_valid),
	.i_tx_is_ctrl(i_tx_is_ctrl), .i_tx_eop(i_tx_eop), .o_tx_short_burst_err(o_tx_short_burst_err),
	.i_rx_valid(i_rx_valid), .i_rx_is_ctrl(i_rx_is_ctrl), .i_rx_word(i_rx_word), .i_rx_crc24_err(i_rx_crc24_err),
	.i_rx_aligned(i_rx_aligned), .i_rx_align_fail(i_rx_align_fail), .i_rx_realign_req(i_rx_realign_req),
	.o_rx_long_burst_err(o_rx_long_burst_err), .o_rx_lane_reset(o_rx_lane_reset),
	.o_rx_aligned_err(o_rx_aligned_err), .i_diag_valid(i_diag_valid), .i_diag_crc_ok(i_diag_crc_ok),
	.o_rx_diag_check_ok(o_rx_diag_check_ok), .o_rx_diag_check_fail(o_rx_diag_check_fail),
	.o_rx_calendar_xon_bits(o_rx_calendar_xon_bits), .o_rx_multi_use_field(o_rx_multi_use_field));

`default_nettype wire

//--- bench/bcs_core_bench.sv
/*
 Self-checking bench of bcs_core; results are read back over the register port, except the interrupt, which is sampled at o_irq.
 Assumes the far model drives the receive stream.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

module bcs_core_bench;
	logic i_clk, i_rst_n, i_wr, i_rd, o_irq, pend, rv, rc, rr, crc, al, af, tv, tc, te;
	logic [7:0] i_addr, mu_e;
	logic [31:0] i_wdata, o_rdata, seed;
	logic [63:0] rw;
	logic [11:0] dv, d33, d32, dok;
	logic [255:0] cal_e;
	logic [31:0] exp_q[$];
	int error_cnt, check_count, cyc, ptr;

	bcs_far_model far (.i_clk(i_clk), .o_valid(rv), .o_is_ctrl(rc), .o_word(rw), .o_realign(rr));
	bcs_core uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_tx_valid(tv), .i_tx_is_ctrl(tc), .i_tx_eop(te),
		.o_tx_short_burst_err(), .i_rx_valid(rv), .i_rx_is_ctrl(rc), .i_rx_word(rw), .i_rx_crc24_err(crc),
		.i_rx_aligned(al), .i_rx_align_fail(af), .i_rx_realign_req(rr), .o_rx_long_burst_err(),
		.o_rx_lane_reset(), .o_rx_aligned_err(), .i_diag_valid(dv), .i_diag_bit33(d33), .i_diag_bit32(d32),
		.i_diag_crc_ok(dok), .o_rx_lane_health_bits(), .o_rx_interface_health_bits(),
		.o_rx_diag_check_ok(), .o_rx_diag_check_fail(), .o_rx_calendar_xon_bits(), .o_rx_multi_use_field());

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] e);
		check_count++;
		if (seen !== e) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, seen, e);
		end
	endtask
	task stop_test;
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask
	task tx(input logic c, input logic e);
		@(posedge i_clk);
		tv <= 1'b1;
		tc <= c;
		te <= e;
		@(posedge i_clk);
		tv <= 1'b0;
	endtask
	// Calendar entries land low bit first from word bit 55
	task sendcw(input logic st);
		logic [63:0] w;
		w = {rnd(), rnd()};
		w[56] = st;
		if (st)
			ptr = 0;
		if (ptr < 16) begin
			for (int k = 0; k < 16; k++)
				cal_e[16 * ptr + k] = w[55 - k];
			ptr++;
		end
		mu_e = w[31:24];
		far.send(1'b1, w);
	endtask
	task rdcal;
		for (int n = 0; n < 8; n++)
			rd(8'h20 + 8'(n * 4), cal_e[n * 32 +: 32]);
	endtask
	task do_reset;
		i_rst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
	endtask
	task pulse_check_irq(input logic e);
		repeat (2) @(posedge i_clk);
		#1 check({31'h0, o_irq}, {31'h0, e});
	endtask
	////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// Timeout and the result monitor share one process
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (pend)
			check(o_rdata, exp_q.pop_front());
		pend <= i_rd;
		if (cyc > 20000) begin
			error_cnt++;
			stop_test;
		end
	end
	initial begin
		{i_rst_n, i_wr, i_rd, pend, crc, af, tv, tc, te} = '0;
		{i_addr, i_wdata, dv, d33, d32, dok, cal_e, mu_e, cyc} = '0;
		al = 1'b1;
		seed = 32'h0001_5C7B;
		ptr = 16;
		error_cnt = 0;
		check_count = 0;
		do_reset;
		rd(8'h00, 32'h0000_0802);
		rd(8'h08, 32'h0);
		rd(8'hFC, 32'h0);
		tx(1, 0); tx(0, 0); tx(1, 0); tx(0, 0); tx(1, 1); tx(0, 0); tx(0, 0); tx(1, 0);
		rd(8'h04, 32'h1);
		pulse_check_irq(1'b0);
		wr(8'h08, 32'h1F);
		pulse_check_irq(1'b1);
		wr(8'h04, 32'h1F);
		pulse_check_irq(1'b0);
		sendcw(0);
		repeat (8) far.send(1'b0, {rnd(), rnd()});
		sendcw(0);
		rd(8'h04, 32'h0);
		repeat (9) far.send(1'b0, {rnd(), rnd()});
		sendcw(0);
		rd(8'h04, 32'h2);
		rd(8'h18, {24'h0, mu_e});
		wr(8'h04, 32'h1F);
		d33 <= 12'(rnd());
		d32 <= 12'(rnd());
		dok <= 12'(rnd()) & 12'hFFE;
		@(posedge i_clk) dv <= 12'hFFF;
		@(posedge i_clk) dv <= 12'h000;
		rd(8'h0C, {20'h0, d33});
		rd(8'h10, {20'h0, d32});
		rd(8'h14, {20'h0, dok});
		rd(8'h04, 32'h4);
		wr(8'h04, 32'h1F);
		// Seventeenth word runs past the calendar end and must be dropped
		sendcw(1);
		repeat (16) sendcw(0);
		rdcal;
		sendcw(1);
		sendcw(0);
		rdcal;
		@(posedge i_clk) crc <= 1'b1;
		@(posedge i_clk) crc <= 1'b0;
		cal_e = '0;
		rdcal;
		rd(8'h04, 32'h10);
		wr(8'h04, 32'h1F);
		sendcw(1);
		@(posedge i_clk) al <= 1'b0;
		cal_e = '0;
		rdcal;
		rd(8'h04, 32'h8);
		wr(8'h04, 32'h1F);
		@(posedge i_clk) af <= 1'b1;
		@(posedge i_clk) af <= 1'b0;
		al <= 1'b1;
		rd(8'h04, 32'h8);
		sendcw(1);
		far.realign(4);
		rd(8'h18, {22'h0, 2'h2, mu_e});
		repeat (6) @(posedge i_clk);
		cal_e = '0;
		rd(8'h18, {24'h0, mu_e});
		rdcal;
		wr(8'h00, 32'h0000_0403);
		rd(8'h00, 32'h0000_0403);
		tx(1, 0); tx(0, 0); tx(0, 0); tx(1, 0);
		rd(8'h04, 32'h9);
		tx(1, 0); tx(0, 0); tx(1, 0);
		do_reset;
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h0000_0802);
		repeat (4) @(posedge i_clk);
		stop_test;
	end
endmodule // bcs_core_bench

`default_nettype wire
